// ---- rtl/pmvw_pkg.sv ----
// Package for the power mode and voltage warning control block.
// Assumes one bus clock and a plain strobe register port.
package pmvw_pkg;
	// Register addresses (index on the plain port)
	localparam logic [2:0] PMVW_ADDR_MODE = 3'h0;
	localparam logic [2:0] PMVW_ADDR_WARN = 3'h1;
	localparam logic [2:0] PMVW_ADDR_IRQ_STATUS = 3'h2;
	localparam logic [2:0] PMVW_ADDR_IRQ_MASK = 3'h3;
	// Power mode control bit positions
	localparam int PMVW_LPR_BIT = 7;
	localparam int PMVW_STBY_BIT = 6;
	localparam int PMVW_WAKE_BIT = 5;
	localparam int PMVW_S2FLAG_BIT = 3;
	localparam int PMVW_S2ACK_BIT = 2;
	localparam int PMVW_PDEN_BIT = 1;
	localparam int PMVW_PDSEL_BIT = 0;
	// Voltage warning control bit positions
	localparam int PMVW_WFLAG_BIT = 7;
	localparam int PMVW_WACK_BIT = 6;
	localparam int PMVW_DTRIP_BIT = 5;
	localparam int PMVW_WTRIP_BIT = 4;
	localparam int PMVW_WIE_BIT = 3;
	// Interrupt status / mask bit positions
	localparam int PMVW_EV_WARN_BIT = 0;
	localparam int PMVW_EV_S2_BIT = 1;
	localparam int PMVW_EV_WAKE_BIT = 2;
	// Reset values
	localparam logic [7:0] PMVW_MODE_RESET = 8'h00;
	localparam logic [7:0] PMVW_WARN_RESET = 8'h00;
	localparam logic [2:0] PMVW_IRQ_RESET = 3'h0;
	// Register bus request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pmvw_bus_t;
	// Power control outputs towards regulator and stop logic
	typedef struct packed {
		logic lowPowerEnable;
		logic wakeOnInterrupt;
		logic partialPowerdownEnable;
		logic powerdownSelect;
		logic detectTripSelect;
		logic warningTripSelect;
	} pmvw_ctrl_t;
endpackage

// ---- rtl/pmvw_ctrl.sv ----
// Power mode control and voltage warning control registers.
// Assumes analog status inputs arrive asynchronously; bus is on clk.
//
// Chosen here: the register addresses and strobed register access.
module pmvw_ctrl
	import pmvw_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic porReset_n,
	input pmvw_pkg::pmvw_bus_t bus,
	output logic [7:0] rdata,
	input wire logic regulatorStandby,
	input wire logic stop2Recovered,
	input wire logic supplyBelowWarning,
	input wire logic mcuInterrupt,
	output pmvw_pkg::pmvw_ctrl_t ctrl,
	output logic warningIrq,
	output logic irq
);
	import pmvw_pkg::*;

	// Synchroniser stages for asynchronous analog and status inputs
	logic [3:0] syncA_reg;
	logic [3:0] syncB_reg;
	logic stbySync;
	logic s2Sync;
	logic lowSync;
	logic intSync;
	logic s2Prev_reg;
	// Control fields
	logic lpr_reg;
	logic wake_reg;
	logic pden_reg;
	logic pdenWritten_reg;
	logic pdsel_reg;
	logic s2Flag_reg;
	logic wflag_reg;
	logic wie_reg;
	logic dtrip_reg;
	logic wtrip_reg;
	// Interrupt bank
	logic [2:0] irqStatus_reg;
	logic [2:0] irqMask_reg;
	// Decoded writes
	logic wrMode;
	logic wrWarn;
	logic wrStat;
	logic wrMask;
	logic s2Rise;
	logic wakeEvent;

	// Two-flop synchroniser; second stage is the only reader of the first
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			syncA_reg <= 4'h0;
			syncB_reg <= 4'h0;
		end
		else
		begin
			syncA_reg <= {mcuInterrupt, supplyBelowWarning, stop2Recovered, regulatorStandby};
			syncB_reg <= syncA_reg;
		end
	end
	assign stbySync = syncB_reg[0];
	assign s2Sync = syncB_reg[1];
	assign lowSync = syncB_reg[2];
	assign intSync = syncB_reg[3];

	// Write decode
	assign wrMode = bus.wr && (bus.addr == PMVW_ADDR_MODE);
	assign wrWarn = bus.wr && (bus.addr == PMVW_ADDR_WARN);
	assign wrStat = bus.wr && (bus.addr == PMVW_ADDR_IRQ_STATUS);
	assign wrMask = bus.wr && (bus.addr == PMVW_ADDR_IRQ_MASK);
	// Interrupt wake only counts while wake bit and low power are set
	assign wakeEvent = wake_reg && lpr_reg && intSync;

	// Low power regulator control; interlock with select bit
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			lpr_reg <= PMVW_MODE_RESET[PMVW_LPR_BIT];
		else if (wakeEvent)
			lpr_reg <= 1'b0;
		else if (wrMode)
		begin
			// Select held or set in same write blocks setting
			if (bus.wdata[PMVW_LPR_BIT] && (pdsel_reg || bus.wdata[PMVW_PDSEL_BIT]))
				lpr_reg <= lpr_reg && !bus.wdata[PMVW_PDSEL_BIT];
			else
				lpr_reg <= bus.wdata[PMVW_LPR_BIT];
		end
	end

	// Powerdown select; refused while regulator control holds 1
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			pdsel_reg <= PMVW_MODE_RESET[PMVW_PDSEL_BIT];
		else if (wrMode)
		begin
			if (bus.wdata[PMVW_PDSEL_BIT] && lpr_reg)
				pdsel_reg <= pdsel_reg;
			else
				pdsel_reg <= bus.wdata[PMVW_PDSEL_BIT];
		end
	end

	// Wake bit and write-once partial powerdown enable
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wake_reg <= PMVW_MODE_RESET[PMVW_WAKE_BIT];
			pden_reg <= PMVW_MODE_RESET[PMVW_PDEN_BIT];
			pdenWritten_reg <= 1'b0;
		end
		else if (wrMode)
		begin
			wake_reg <= bus.wdata[PMVW_WAKE_BIT];
			// Later writes silently dropped until next reset
			if (!pdenWritten_reg)
			begin
				pden_reg <= bus.wdata[PMVW_PDEN_BIT];
				pdenWritten_reg <= 1'b1;
			end
		end
	end

	// Stop2 recovery flag; new recovery wins over ack
	assign s2Rise = s2Sync && !s2Prev_reg;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s2Prev_reg <= 1'b0;
			s2Flag_reg <= 1'b0;
		end
		else
		begin
			s2Prev_reg <= s2Sync;
			if (s2Rise)
				s2Flag_reg <= 1'b1;
			else if (wrMode && bus.wdata[PMVW_S2ACK_BIT])
				s2Flag_reg <= 1'b0;
		end
	end

	// Warning flag and interrupt enable; low supply always wins
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wflag_reg <= PMVW_WARN_RESET[PMVW_WFLAG_BIT];
			wie_reg <= PMVW_WARN_RESET[PMVW_WIE_BIT];
		end
		else
		begin
			// Level driven, so flag rises right after reset if still low
			if (lowSync)
				wflag_reg <= 1'b1;
			else if (wrWarn && bus.wdata[PMVW_WACK_BIT])
				wflag_reg <= 1'b0;
			if (wrWarn)
				wie_reg <= bus.wdata[PMVW_WIE_BIT];
		end
	end

	// Trip selects only cleared by power-on reset
	always_ff @(posedge clk or negedge porReset_n)
	begin
		if (!porReset_n)
		begin
			dtrip_reg <= PMVW_WARN_RESET[PMVW_DTRIP_BIT];
			wtrip_reg <= PMVW_WARN_RESET[PMVW_WTRIP_BIT];
		end
		else if (wrWarn)
		begin
			// Detect high with warning low is not blocked here
			dtrip_reg <= bus.wdata[PMVW_DTRIP_BIT];
			wtrip_reg <= bus.wdata[PMVW_WTRIP_BIT];
		end
	end

	// Sticky event bank, write one to clear, set wins
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irqStatus_reg <= PMVW_IRQ_RESET;
			irqMask_reg <= PMVW_IRQ_RESET;
		end
		else
		begin
			irqStatus_reg <= (irqStatus_reg & ~(wrStat ? bus.wdata[2:0] : 3'h0))
				| {wakeEvent, s2Rise, lowSync && !wflag_reg};
			if (wrMask)
				irqMask_reg <= bus.wdata[2:0];
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rdata <= 8'h00;
		else if (bus.rd)
		begin
			case (bus.addr)
				PMVW_ADDR_MODE: rdata <= {lpr_reg, stbySync, wake_reg, 1'b0, s2Flag_reg, 1'b0, pden_reg, pdsel_reg};
				PMVW_ADDR_WARN: rdata <= {wflag_reg, 1'b0, dtrip_reg, wtrip_reg, wie_reg, 3'h0};
				PMVW_ADDR_IRQ_STATUS: rdata <= {5'h00, irqStatus_reg};
				PMVW_ADDR_IRQ_MASK: rdata <= {5'h00, irqMask_reg};
				default: rdata <= 8'h00; // Unmapped reads zero
			endcase
		end
		else
			rdata <= 8'h00;
	end

	// Outputs
	assign warningIrq = wie_reg && wflag_reg;
	assign irq = |(irqStatus_reg & irqMask_reg);
	assign ctrl = '{lowPowerEnable: lpr_reg, wakeOnInterrupt: wake_reg, partialPowerdownEnable: pden_reg,
		powerdownSelect: pdsel_reg, detectTripSelect: dtrip_reg, warningTripSelect: wtrip_reg};

	// Assertions
	// All checks sample on the bus clock and sleep through the plain reset
	// Synchronised inputs are used so the checks see what the logic sees;
	// only the warning flag check samples the raw supplyBelowWarning pin

	// Regulator control refused while select already holds 1
	property p_lpr_refused;
		@(posedge clk) disable iff (!reset_n)
		(wrMode && pdsel_reg && !wakeEvent) |=> !lpr_reg;
	endproperty
	a_lpr_refused: assert property (p_lpr_refused) else $error("lpr set while select held");

	// Both bits in one write with the regulator bit clear leave only the select bit
	property p_both_set;
		@(posedge clk) disable iff (!reset_n)
		(wrMode && !lpr_reg && !wakeEvent && bus.wdata[PMVW_LPR_BIT] && bus.wdata[PMVW_PDSEL_BIT])
			|=> (pdsel_reg && !lpr_reg);
	endproperty
	a_both_set: assert property (p_both_set) else $error("both set not resolved to select");

	// Plain write with select clear loads the regulator bit
	property p_lpr_load;
		@(posedge clk) disable iff (!reset_n)
		(wrMode && !wakeEvent && !pdsel_reg && !bus.wdata[PMVW_PDSEL_BIT])
			|=> (lpr_reg == $past(bus.wdata[PMVW_LPR_BIT]));
	endproperty
	a_lpr_load: assert property (p_lpr_load) else $error("regulator bit not loaded");

	// Interrupt with wake bit always drops the regulator bit
	property p_wake_clear;
		@(posedge clk) disable iff (!reset_n)
		wakeEvent |=> !lpr_reg;
	endproperty
	a_wake_clear: assert property (p_wake_clear) else $error("wake did not clear lpr");

	// Standby status read back as sampled in the strobe cycle
	property p_stby_read;
		@(posedge clk) disable iff (!reset_n)
		(bus.rd && bus.addr == PMVW_ADDR_MODE) |=> (rdata[PMVW_STBY_BIT] == $past(stbySync));
	endproperty
	a_stby_read: assert property (p_stby_read) else $error("standby status misread");

	// Wake bit follows every mode write
	property p_wake_load;
		@(posedge clk) disable iff (!reset_n)
		wrMode |=> (wake_reg == $past(bus.wdata[PMVW_WAKE_BIT]));
	endproperty
	a_wake_load: assert property (p_wake_load) else $error("wake bit not loaded");

	// Recovery edge raises the flag on the next edge
	property p_s2_set;
		@(posedge clk) disable iff (!reset_n)
		s2Rise |=> s2Flag_reg;
	endproperty
	a_s2_set: assert property (p_s2_set) else $error("recovery flag not set");

	// Ack clears the flag unless a new recovery lands with it
	property p_s2_ack;
		@(posedge clk) disable iff (!reset_n)
		(wrMode && bus.wdata[PMVW_S2ACK_BIT] && !s2Rise) |=> !s2Flag_reg;
	endproperty
	a_s2_ack: assert property (p_s2_ack) else $error("recovery ack failed");

	// Once written, the enable bit never moves until reset
	property p_pden_once;
		@(posedge clk) disable iff (!reset_n)
		pdenWritten_reg |=> $stable(pden_reg);
	endproperty
	a_pden_once: assert property (p_pden_once) else $error("pden changed after first write");

	// First write after reset is taken as written
	property p_pden_first;
		@(posedge clk) disable iff (!reset_n)
		(wrMode && !pdenWritten_reg) |=> (pden_reg == $past(bus.wdata[PMVW_PDEN_BIT]));
	endproperty
	a_pden_first: assert property (p_pden_first) else $error("first pden write lost");

	// With the regulator bit clear the select bit follows the write
	property p_sel_load;
		@(posedge clk) disable iff (!reset_n)
		(wrMode && !lpr_reg) |=> (pdsel_reg == $past(bus.wdata[PMVW_PDSEL_BIT]));
	endproperty
	a_sel_load: assert property (p_sel_load) else $error("select bit not loaded");

	// Select refused while regulator control holds 1
	property p_sel_refused;
		@(posedge clk) disable iff (!reset_n)
		(wrMode && lpr_reg && !pdsel_reg) |=> !pdsel_reg;
	endproperty
	a_sel_refused: assert property (p_sel_refused) else $error("select set while lpr held");

	// Warning flag rises once low supply has passed the synchroniser
	property p_warn_set;
		@(posedge clk) disable iff (!reset_n)
		$rose(supplyBelowWarning) ##0 supplyBelowWarning [*3] |=> wflag_reg;
	endproperty
	a_warn_set: assert property (p_warn_set) else $error("warning flag not set");

	// Ack refused while supply is still low
	property p_warn_ack;
		@(posedge clk) disable iff (!reset_n)
		(wrWarn && bus.wdata[PMVW_WACK_BIT] && lowSync) |=> wflag_reg;
	endproperty
	a_warn_ack: assert property (p_warn_ack) else $error("flag cleared while low");

	// Trip selects take every warning write; only power-on reset clears them
	property p_trip_load;
		@(posedge clk) disable iff (!reset_n || !porReset_n)
		wrWarn |=> (dtrip_reg == $past(bus.wdata[PMVW_DTRIP_BIT])
			&& wtrip_reg == $past(bus.wdata[PMVW_WTRIP_BIT]));
	endproperty
	a_trip_load: assert property (p_trip_load) else $error("trip select not loaded");

	// Enabled interrupt follows low supply one edge later
	property p_warn_irq;
		@(posedge clk) disable iff (!reset_n)
		(lowSync && wie_reg && !wrWarn) |=> warningIrq;
	endproperty
	a_warn_irq: assert property (p_warn_irq) else $error("warning irq missing");

	// Reserved and ack bits read as zero
	property p_read_zero;
		@(posedge clk) disable iff (!reset_n)
		(bus.rd && bus.addr == PMVW_ADDR_WARN) |=> (rdata[2:0] == 3'h0 && !rdata[PMVW_WACK_BIT]);
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("reserved bits nonzero");

	// Covers for the main scenarios
	c_wake: cover property (@(posedge clk) disable iff (!reset_n) wakeEvent);
	c_s2: cover property (@(posedge clk) disable iff (!reset_n) s2Rise ##[1:20] !s2Flag_reg);
	c_warn: cover property (@(posedge clk) disable iff (!reset_n) warningIrq ##[1:50] !wflag_reg);
	c_irq: cover property (@(posedge clk) disable iff (!reset_n) irq);
	c_both: cover property (@(posedge clk) disable iff (!reset_n)
		wrMode && bus.wdata[PMVW_LPR_BIT] && bus.wdata[PMVW_PDSEL_BIT]);
endmodule // pmvw_ctrl

// ---- tb/pmvw_ctrl_test.sv ----
// Self-checking bench for the power mode and voltage warning block.
// Assumes the block alone on a 20 MHz clock, driven straight by this bench.
module pmvw_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	import pmvw_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic porReset_n = 1'b0;
	pmvw_bus_t bus = '0; // Register port request
	logic [7:0] rdata;
	logic regulatorStandby = 1'b0;
	logic stop2Recovered = 1'b0;
	logic supplyBelowWarning = 1'b0;
	logic mcuInterrupt = 1'b0;
	pmvw_ctrl_t ctrl;
	logic warningIrq;
	logic irq;
	int nFail = 0; // Mismatch count
	int checksDone = 0; // Comparison count
	// Device under test
	pmvw_ctrl i_pmvw_ctrl (
		.clk(clk),
		.reset_n(reset_n),
		.porReset_n(porReset_n),
		.bus(bus),
		.rdata(rdata),
		.regulatorStandby(regulatorStandby),
		.stop2Recovered(stop2Recovered),
		.supplyBelowWarning(supplyBelowWarning),
		.mcuInterrupt(mcuInterrupt),
		.ctrl(ctrl),
		.warningIrq(warningIrq),
		.irq(irq)
	);
	// 50 ns clock
	initial
	begin
		forever #25 clk = ~clk;
	end
	// Verdict and end of run
	task automatic finishTest();
		$display("checks %0d mismatches %0d", checksDone, nFail);
		if (nFail == 0 && checksDone > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// One-cycle write strobe; returns one edge after the taking edge, so fields have settled
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus.wr <= 1'b1;
		bus.addr <= a;
		bus.wdata <= d;
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask
	// Read and compare; data stand only in the cycle after the strobe, taken at its closing edge
	task automatic chkReg(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge clk);
		bus.rd <= 1'b0;
		@(posedge clk);
		checksDone++;
		if (rdata !== e)
		begin
			nFail++;
			$display("MISMATCH %0t reg %0h got %0h exp %0h", $time, a, rdata, e);
		end
	endtask
	// Single output bit compare
	task automatic chkBit(input logic g, input logic e);
		checksDone++;
		if (g !== e)
		begin
			nFail++;
			$display("MISMATCH %0t bit got %b exp %b", $time, g, e);
		end
	endtask
	// Hang guard: a used-up bound counts as a mismatch
	initial
	begin
		repeat (20000) @(posedge clk);
		nFail++;
		finishTest();
	end
	// Main sequence
	initial
	begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		porReset_n <= 1'b1;
		chkReg(PMVW_ADDR_MODE, 8'h00);
		chkReg(PMVW_ADDR_WARN, 8'h00);
		// Standby status follows the regulator after the synchroniser
		regulatorStandby <= 1'b1;
		repeat (5) @(posedge clk);
		chkReg(PMVW_ADDR_MODE, 8'h40);
		regulatorStandby <= 1'b0;
		repeat (5) @(posedge clk);
		wr(PMVW_ADDR_MODE, 8'h22);
		chkBit(ctrl.wakeOnInterrupt, 1'b1);
		chkBit(ctrl.partialPowerdownEnable, 1'b1);
		// Second write must not touch the write-once bit
		wr(PMVW_ADDR_MODE, 8'h00);
		chkReg(PMVW_ADDR_MODE, 8'h02);
		wr(PMVW_ADDR_MODE, 8'h81);
		chkReg(PMVW_ADDR_MODE, 8'h03);
		chkBit(ctrl.powerdownSelect, 1'b1);
		wr(PMVW_ADDR_MODE, 8'h81);
		chkReg(PMVW_ADDR_MODE, 8'h03);
		wr(PMVW_ADDR_MODE, 8'h02);
		wr(PMVW_ADDR_MODE, 8'h82);
		chkReg(PMVW_ADDR_MODE, 8'h82);
		chkBit(ctrl.lowPowerEnable, 1'b1);
		wr(PMVW_ADDR_MODE, 8'h01);
		chkReg(PMVW_ADDR_MODE, 8'h02);
		// Interrupt with wake bit drops the regulator bit
		wr(PMVW_ADDR_MODE, 8'ha2);
		mcuInterrupt <= 1'b1;
		repeat (5) @(posedge clk);
		chkReg(PMVW_ADDR_MODE, 8'h22);
		mcuInterrupt <= 1'b0;
		stop2Recovered <= 1'b1;
		repeat (5) @(posedge clk);
		chkReg(PMVW_ADDR_MODE, 8'h2a);
		wr(PMVW_ADDR_MODE, 8'h26);
		chkReg(PMVW_ADDR_MODE, 8'h22);
		chkReg(PMVW_ADDR_IRQ_STATUS, 8'h06);
		// Ack refused while the supply stays low
		supplyBelowWarning <= 1'b1;
		repeat (5) @(posedge clk);
		chkReg(PMVW_ADDR_WARN, 8'h80);
		wr(PMVW_ADDR_WARN, 8'h40);
		chkReg(PMVW_ADDR_WARN, 8'h80);
		wr(PMVW_ADDR_WARN, 8'h3f);
		chkReg(PMVW_ADDR_WARN, 8'hb8);
		chkBit(ctrl.detectTripSelect, 1'b1);
		chkBit(ctrl.warningTripSelect, 1'b1);
		chkBit(warningIrq, 1'b1);
		// Status, mask and level output
		chkBit(irq, 1'b0);
		wr(PMVW_ADDR_IRQ_MASK, 8'h01);
		chkBit(irq, 1'b1);
		wr(PMVW_ADDR_IRQ_STATUS, 8'h07);
		chkBit(irq, 1'b0);
		chkReg(PMVW_ADDR_IRQ_STATUS, 8'h00);
		supplyBelowWarning <= 1'b0;
		repeat (5) @(posedge clk);
		wr(PMVW_ADDR_WARN, 8'h78);
		chkReg(PMVW_ADDR_WARN, 8'h38);
		chkBit(warningIrq, 1'b0);
		chkReg(3'h7, 8'h00);
		// Plain reset keeps trip selects; low supply flags at once
		supplyBelowWarning <= 1'b1;
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		chkReg(PMVW_ADDR_WARN, 8'hb0);
		// Reset re-arms the write-once bit: first write taken, second dropped
		wr(PMVW_ADDR_MODE, 8'h02);
		wr(PMVW_ADDR_MODE, 8'h00);
		chkBit(ctrl.partialPowerdownEnable, 1'b1);
		// Power-on reset clears trip selects
		reset_n <= 1'b0;
		porReset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		porReset_n <= 1'b1;
		repeat (5) @(posedge clk);
		chkReg(PMVW_ADDR_WARN, 8'h80);
		finishTest();
	end
endmodule // pmvw_ctrl_test
